// >>> error_history_logger.sv
// Purpose: error history tables, critical-record mirroring and ethernet error indication
// Assumes: nonvolatile store answers read, write and erase handshakes
// Notes:   legacy_mode is a static strap; fatal indication holds until reset
`default_nettype none
`timescale 1ns/10ps
module error_history_logger #(
  parameter logic [35:0] OPTIME_CYC = 36'(error_history_pkg::OPTIME_CYC),
  parameter logic [31:0] ALT_CYC    = 32'(error_history_pkg::ALT_CYC)
) (
  input  wire logic                         sys_clk,
  input  wire logic                         arst_n,
  input  wire logic                         clk_en,
  input  wire logic                         legacy_mode,
  input  wire logic                         gen_valid,
  input  wire error_history_pkg::gen_evt_t  gen_evt,
  output logic                              gen_ready,
  input  wire logic                         eth_valid,
  input  wire error_history_pkg::eth_evt_t  eth_evt,
  output logic                              eth_ready,
  input  wire logic [7:0]                   local_node_addr,
  input  wire logic                         io_grant,
  input  wire logic                         io_refresh,
  input  wire logic                         io_release,
  input  wire logic [15:0]                  refresh_limit,
  input  wire logic                         clr_req,
  output logic                              clr_ready,
  input  wire logic                         rd_req,
  input  wire logic                         rd_sel,
  input  wire logic [6:0]                   rd_idx,
  output logic                              rd_valid,
  output logic                              rd_hit,
  output error_history_pkg::record_t        rd_data,
  output logic                              nvm_rd_req,
  output logic [6:0]                        nvm_rd_idx,
  input  wire logic                         nvm_rd_valid,
  input  wire logic                         nvm_rd_end,
  input  wire error_history_pkg::record_t   nvm_rd_data,
  output logic                              nvm_wr_valid,
  output error_history_pkg::record_t        nvm_wr_data,
  input  wire logic                         nvm_wr_ready,
  output logic                              nvm_erase,
  input  wire logic                         nvm_erase_done,
  output error_history_pkg::lamp_t          network_status_lamp,
  output error_history_pkg::lamp_t          module_status_lamp,
  output logic [15:0]                       disp_chars,
  output logic [6:0]                        main_count,
  output logic [6:0]                        eth_count
);
  // ****************************************************************
  // state and handshakes
  // ****************************************************************
  error_history_pkg::state_t    s_ff;
  error_history_pkg::state_t    nxt_s;
  error_history_pkg::record_t   rec;
  error_history_pkg::eth_kind_t kind;
  logic [6:0]                   main_cap;
  logic [6:0]                   wr_pos;
  logic                         idle;
  logic                         ready;
  logic                         take_clr;
  logic                         take_eth;
  logic                         take_gen;
  logic                         load_rst;

  function automatic logic [6:0] wrap(input logic [6:0] a, input logic [6:0] b,
                                      input logic [6:0] cap);
    logic [7:0] t;
    t = {1'b0, a} + {1'b0, b};
    if (t >= {1'b0, cap}) t = t - {1'b0, cap};
    return t[6:0];
  endfunction

  assign main_cap  = legacy_mode ? error_history_pkg::LEGACY_DEPTH
                                 : error_history_pkg::MAIN_DEPTH;
  assign idle      = clk_en && (s_ff.fsm == error_history_pkg::st_idle)
                     && !s_ff.nvm_wr_pend && !s_ff.nvm_er_pend;
  assign clr_ready = idle;
  assign take_clr  = idle && clr_req;
  assign ready     = idle && !clr_req;
  assign eth_ready = ready && !s_ff.wto_pend;
  assign take_eth  = ready && (s_ff.wto_pend || eth_valid);
  assign gen_ready = ready && !s_ff.wto_pend && !eth_valid;
  assign take_gen  = gen_ready && gen_valid;
  assign load_rst  = clk_en && (s_ff.fsm == error_history_pkg::st_wait)
                     && nvm_rd_valid && !nvm_rd_end;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    nxt_s  = s_ff;
    rec    = '0;
    wr_pos = '0;
    kind   = s_ff.wto_pend ? error_history_pkg::ek_wto : eth_evt.kind;
    if (clk_en) begin
      // operating time stamp
      if (s_ff.optime_div >= OPTIME_CYC - 36'h1) begin
        nxt_s.optime_div = '0;
        nxt_s.optime     = s_ff.optime + 16'h1;
      end else begin
        nxt_s.optime_div = s_ff.optime_div + 36'h1;
      end
      // display alternation
      if (s_ff.alt_div >= ALT_CYC - 32'h1) begin
        nxt_s.alt_div   = '0;
        nxt_s.alt_phase = !s_ff.alt_phase;
      end else begin
        nxt_s.alt_div = s_ff.alt_div + 32'h1;
      end
      // restore from nonvolatile store
      unique case (s_ff.fsm)
        error_history_pkg::st_restore: begin
          nxt_s.fsm = error_history_pkg::st_wait;
        end
        error_history_pkg::st_wait: begin
          if (nvm_rd_valid) begin
            nxt_s.rst_idx = s_ff.rst_idx + 7'h1;
            if (nvm_rd_end || s_ff.rst_idx == error_history_pkg::MAIN_DEPTH - 7'h1) begin
              nxt_s.fsm = error_history_pkg::st_idle;
            end else begin
              nxt_s.fsm = error_history_pkg::st_restore;
            end
          end
        end
        error_history_pkg::st_idle: begin
        end
      endcase
      // nonvolatile handshakes
      if (s_ff.nvm_wr_pend && nvm_wr_ready) nxt_s.nvm_wr_pend = 1'b0;
      if (s_ff.nvm_er_pend && nvm_erase_done) nxt_s.nvm_er_pend = 1'b0;
      // history read, oldest first
      nxt_s.rd_valid = rd_req;
      nxt_s.rd_hit   = 1'b0;
      nxt_s.rd_data  = '0;
      if (rd_req && !rd_sel && rd_idx < s_ff.main_cnt) begin
        nxt_s.rd_hit  = 1'b1;
        nxt_s.rd_data = s_ff.main_mem[wrap(s_ff.main_head, rd_idx, main_cap)];
      end else if (rd_req && rd_sel && rd_idx < s_ff.eth_cnt) begin
        nxt_s.rd_hit  = 1'b1;
        nxt_s.rd_data = s_ff.eth_mem[wrap(s_ff.eth_head, rd_idx,
                                          error_history_pkg::ETH_DEPTH)];
      end
      // append to main table
      if (take_gen || load_rst) begin
        rec = take_gen ? error_history_pkg::record_t'{status: gen_evt.status,
                           optime: s_ff.optime, detail: gen_evt.detail} : nvm_rd_data;
        wr_pos = wrap(s_ff.main_head, s_ff.main_cnt, main_cap);
        nxt_s.main_mem[wr_pos] = rec;
        if (s_ff.main_cnt >= main_cap) begin
          nxt_s.main_head = wrap(s_ff.main_head, 7'h1, main_cap);
        end else begin
          nxt_s.main_cnt = s_ff.main_cnt + 7'h1;
        end
        if (take_gen && gen_evt.critical) begin
          nxt_s.nvm_wr_pend = 1'b1;
          nxt_s.nvm_wr_rec  = rec;
        end
      end
      // append to ethernet table and indicate
      if (take_eth) begin
        rec = '{status: error_history_pkg::STATUS_ETH | {4'h0, kind}, optime: s_ff.optime,
                detail: (kind == error_history_pkg::ek_wto) ? local_node_addr
                                                            : eth_evt.detail};
        wr_pos = wrap(s_ff.eth_head, s_ff.eth_cnt, error_history_pkg::ETH_DEPTH);
        nxt_s.eth_mem[wr_pos[5:0]] = rec;
        if (s_ff.eth_cnt >= error_history_pkg::ETH_DEPTH) begin
          nxt_s.eth_head = wrap(s_ff.eth_head, 7'h1, error_history_pkg::ETH_DEPTH);
        end else begin
          nxt_s.eth_cnt = s_ff.eth_cnt + 7'h1;
        end
        nxt_s.nvm_wr_pend = 1'b1;
        nxt_s.nvm_wr_rec  = rec;
        nxt_s.wto_pend    = 1'b0;
        if (!s_ff.fatal) begin
          nxt_s.shown      = 1'b1;
          nxt_s.shown_kind = kind;
          nxt_s.shown_node = local_node_addr;
          unique case (kind)
            error_history_pkg::ek_adaptor: begin
              nxt_s.fatal    = 1'b1;
              nxt_s.net_lamp = error_history_pkg::lamp_off;
              nxt_s.mod_lamp = error_history_pkg::lamp_red;
            end
            error_history_pkg::ek_ip_dup: begin
              nxt_s.net_lamp = error_history_pkg::lamp_red;
            end
            error_history_pkg::ek_bootp, error_history_pkg::ek_basic,
            error_history_pkg::ek_link: begin
              nxt_s.net_lamp = error_history_pkg::lamp_off;
            end
            error_history_pkg::ek_mem, error_history_pkg::ek_comm: begin
              nxt_s.net_lamp = error_history_pkg::lamp_off;
              nxt_s.mod_lamp = error_history_pkg::lamp_red;
            end
            error_history_pkg::ek_tag: begin
              nxt_s.net_lamp = error_history_pkg::lamp_red_flash;
            end
            error_history_pkg::ek_wto: begin
            end
            default: begin
              nxt_s.shown = s_ff.shown;
            end
          endcase
        end
      end
      // clear both copies
      if (take_clr) begin
        nxt_s.main_head   = '0;
        nxt_s.main_cnt    = '0;
        nxt_s.eth_head    = '0;
        nxt_s.eth_cnt     = '0;
        nxt_s.nvm_er_pend = 1'b1;
      end
      // refresh watchdog; a new timeout set wins over the take above
      if (io_grant) begin
        nxt_s.wto_active = 1'b1;
        nxt_s.wto_cnt    = '0;
      end else if (io_release) begin
        nxt_s.wto_active = 1'b0;
      end else if (s_ff.wto_active) begin
        if (io_refresh) begin
          nxt_s.wto_cnt = '0;
        end else if (s_ff.wto_cnt >= refresh_limit) begin
          nxt_s.wto_active = 1'b0;
          nxt_s.wto_pend   = 1'b1;
        end else begin
          nxt_s.wto_cnt = s_ff.wto_cnt + 16'h1;
        end
      end
      // display: code, then n4 or node address
      if (!nxt_s.shown) begin
        nxt_s.disp = error_history_pkg::SHOW_BLANK;
      end else if (nxt_s.fatal || !nxt_s.alt_phase) begin
        nxt_s.disp = error_history_pkg::code_of(nxt_s.shown_kind);
      end else if (nxt_s.shown_kind == error_history_pkg::ek_wto) begin
        nxt_s.disp = {error_history_pkg::hex_ch(nxt_s.shown_node[7:4]),
                      error_history_pkg::hex_ch(nxt_s.shown_node[3:0])};
      end else begin
        nxt_s.disp = error_history_pkg::SHOW_N4;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_ff <= error_history_pkg::STATE_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign rd_valid            = s_ff.rd_valid;
  assign rd_hit              = s_ff.rd_hit;
  assign rd_data             = s_ff.rd_data;
  assign nvm_rd_req          = (s_ff.fsm == error_history_pkg::st_restore);
  assign nvm_rd_idx          = s_ff.rst_idx;
  assign nvm_wr_valid        = s_ff.nvm_wr_pend;
  assign nvm_wr_data         = s_ff.nvm_wr_rec;
  assign nvm_erase           = s_ff.nvm_er_pend;
  assign network_status_lamp = s_ff.net_lamp;
  assign module_status_lamp  = s_ff.mod_lamp;
  assign disp_chars          = s_ff.disp;
  assign main_count          = s_ff.main_cnt;
  assign eth_count           = s_ff.eth_cnt;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  a_main_full: assert property (!legacy_mode && take_gen
    && s_ff.main_cnt == error_history_pkg::MAIN_DEPTH |=> s_ff.main_cnt ==
    error_history_pkg::MAIN_DEPTH && s_ff.main_head != $past(s_ff.main_head))
    else $error("main table did not overwrite oldest");
  a_legacy_full: assert property (legacy_mode && take_gen
    && s_ff.main_cnt == error_history_pkg::LEGACY_DEPTH |=> s_ff.main_cnt ==
    error_history_pkg::LEGACY_DEPTH && s_ff.main_head != $past(s_ff.main_head))
    else $error("legacy table did not overwrite oldest");
  a_rec_time: assert property (take_gen
    |=> s_ff.main_mem[$past(wr_pos)].optime == $past(s_ff.optime))
    else $error("record time stamp wrong");
  a_eth_full: assert property (take_eth
    && s_ff.eth_cnt == error_history_pkg::ETH_DEPTH
    |=> s_ff.eth_cnt == error_history_pkg::ETH_DEPTH && $changed(s_ff.eth_head))
    else $error("ethernet table did not overwrite oldest");
  a_crit_nvm: assert property (take_gen && gen_evt.critical
    |=> nvm_wr_valid && nvm_wr_data.status == $past(gen_evt.status))
    else $error("critical record not mirrored");
  a_restore_load: assert property (load_rst && s_ff.main_cnt < main_cap
    |=> s_ff.main_cnt == $past(s_ff.main_cnt) + 7'h1)
    else $error("restored record not loaded");
  a_read_ram: assert property (clk_en && rd_req && !rd_sel && rd_idx == 7'h0
    && s_ff.main_cnt != 7'h0 |=> rd_hit && rd_data == $past(s_ff.main_mem[s_ff.main_head]))
    else $error("read did not return oldest RAM record");
  a_clear_both: assert property (take_clr
    |=> s_ff.main_cnt == 7'h0 && s_ff.eth_cnt == 7'h0 && nvm_erase)
    else $error("clear missed a copy");
  a_fatal_show: assert property (take_eth && kind == error_history_pkg::ek_adaptor
    |=> network_status_lamp == error_history_pkg::lamp_off && module_status_lamp ==
    error_history_pkg::lamp_red && disp_chars == 16'h5546 && nvm_wr_valid)
    else $error("fatal indication wrong");
  a_ip_dup: assert property (take_eth && !s_ff.fatal
    && kind == error_history_pkg::ek_ip_dup
    |=> network_status_lamp == error_history_pkg::lamp_red)
    else $error("address clash lamp wrong");
  a_tag_flash: assert property (take_eth && !s_ff.fatal
    && kind == error_history_pkg::ek_tag
    |=> network_status_lamp == error_history_pkg::lamp_red_flash)
    else $error("tag link lamp wrong");
  a_wto_fire: assert property (clk_en && s_ff.wto_active && !io_grant
    && !io_release && !io_refresh && s_ff.wto_cnt >= refresh_limit |=> s_ff.wto_pend)
    else $error("refresh timeout not logged");
  a_optime_step: assert property (clk_en && s_ff.optime_div == OPTIME_CYC - 36'h1
    |=> s_ff.optime == $past(s_ff.optime) + 16'h1 && s_ff.optime_div == 36'h0)
    else $error("operating time step wrong");

  c_restore:   cover property (load_rst);
  c_overwrite: cover property (take_gen && s_ff.main_cnt == main_cap);
  c_fatal:     cover property (take_eth && kind == error_history_pkg::ek_adaptor);
  c_clear:     cover property (take_clr);
endmodule
`default_nettype wire

// >>> error_history_logger_test.sv
// Purpose: self-checking bench of the error history logger
// Assumes: shortened operating-time and alternation counts
// Notes:   legacy strap raised under a mid-run reset for the last scenario
`timescale 1ns/10ps
`default_nettype none
module error_history_logger_test;
  logic        sys_clk = 0, arst_n = 0, gen_valid = 0, eth_valid = 0, clr_req = 0, rd_req = 0;
  logic        io_grant = 0, io_refresh = 0, io_release = 0, rd_sel = 0, legacy_mode = 0;
  logic [6:0]  rd_idx = 0, main_count, eth_count, nvm_rd_idx;
  logic [15:0] refresh_limit = 16'h000a, disp_chars;
  logic        gen_ready, eth_ready, clr_ready, rd_valid, rd_hit, nvm_rd_req, nvm_rd_valid;
  logic        nvm_rd_end, nvm_wr_valid, nvm_wr_ready, nvm_erase, nvm_erase_done;
  error_history_pkg::gen_evt_t gen_evt = '0;
  error_history_pkg::eth_evt_t eth_evt = '0;
  error_history_pkg::record_t  rd_data, nvm_rd_data, nvm_wr_data, r;
  error_history_pkg::lamp_t    network_status_lamp, module_status_lamp;
  int          err_count = 0, checks = 0, stored, n, s0;
  logic [15:0] code [8] = '{16'h5546, 16'h4630, 16'h4533, 16'h4632, 16'h4539, 16'h4634,
                            16'h4c39, 16'h4531};
  logic [1:0]  lamp [8] = '{2'h0, 2'h2, 2'h0, 2'h0, 2'h0, 2'h0, 2'h3, 2'h0};
  error_history_logger #(.OPTIME_CYC(36'h14), .ALT_CYC(32'h8)) error_history_logger_i (
    .sys_clk, .arst_n, .clk_en(1'b1), .legacy_mode, .gen_valid, .gen_evt, .gen_ready,
    .eth_valid, .eth_evt, .eth_ready, .local_node_addr(8'h3c), .io_grant, .io_refresh,
    .io_release, .refresh_limit, .clr_req, .clr_ready, .rd_req, .rd_sel, .rd_idx, .rd_valid,
    .rd_hit, .rd_data, .nvm_rd_req, .nvm_rd_idx, .nvm_rd_valid, .nvm_rd_end, .nvm_rd_data,
    .nvm_wr_valid, .nvm_wr_data, .nvm_wr_ready, .nvm_erase, .nvm_erase_done,
    .network_status_lamp, .module_status_lamp, .disp_chars, .main_count, .eth_count);
  nvm_store_model nvm_store_model_i (.sys_clk, .nvm_rd_req, .nvm_rd_idx, .nvm_rd_valid,
    .nvm_rd_end, .nvm_rd_data, .nvm_wr_valid, .nvm_wr_data, .nvm_wr_ready, .nvm_erase,
    .nvm_erase_done, .stored);
  // ****************
  // shared tasks
  // ****************
  task chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task send(input bit e, input logic [16:0] v);
    @(posedge sys_clk);
    eth_valid <= e;
    gen_valid <= !e;
    eth_evt <= v[11:0];
    gen_evt <= v;
    n = 0;
    do @(negedge sys_clk) n++; while ((e ? eth_ready : gen_ready) !== 1'b1 && n < 300);
    @(posedge sys_clk);
    eth_valid <= 0;
    gen_valid <= 0;
    #1 chk(n < 300, "event never taken");
  endtask
  task rd(input logic s, input logic [6:0] i);
    @(posedge sys_clk);
    rd_req <= 1;
    rd_sel <= s;
    rd_idx <= i;
    @(posedge sys_clk);
    rd_req <= 0;
    #1 r = rd_data;
    chk(rd_valid, "read answer missing");
  endtask
  task summarize;
    if (err_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ****************
  // scenarios
  // ****************
  task t_restore_gen;
    n = 0;
    do @(negedge sys_clk) n++; while (gen_ready !== 1'b1 && n < 100);
    chk(main_count === 7'h02, "restore count");
    rd(0, 0);
    chk(r === 32'h010000a0 && rd_hit === 1'b1, "restored record");
    send(0, {8'h01, 8'h10, 1'b0});
    repeat (4) @(posedge sys_clk);
    chk(stored == 2 && main_count === 7'h03, "plain record mirrored");
    send(0, {8'h05, 8'h11, 1'b1});
    chk(nvm_wr_valid === 1'b1 && nvm_wr_data.detail === 8'h11, "critical write data");
    repeat (4) @(posedge sys_clk);
    chk(stored == 3, "critical not mirrored");
    rd(0, 3);
    chk(r.status === 8'h05 && r.detail === 8'h11, "record fields");
  endtask
  task t_main_wrap;
    for (int j = 0; j < 100; j++) send(0, {8'h02, 8'(j), 1'b0});
    chk(main_count === error_history_pkg::MAIN_DEPTH, "main depth");
    rd(0, 0);
    chk(r.detail === 8'h00 && r.status === 8'h02, "oldest kept");
    rd(0, 7'h63);
    chk(r.detail === 8'h63 && r.optime !== 16'h0, "newest record");
  endtask
  task t_eth_kinds;
    for (int k = 1; k < 8; k++) begin
      send(1, {5'h0, 4'(k), 8'(k - 1)});
      chk(network_status_lamp === lamp[k], "network lamp");
      chk(disp_chars === code[k] || disp_chars === 16'h6e34, "code");
      if (k == 4 || k == 5) chk(module_status_lamp === 2'h2, "module lamp");
    end
    chk(eth_count === 7'h07, "eth count");
  endtask
  task t_watchdog;
    @(posedge sys_clk) io_grant <= 1;
    @(posedge sys_clk) io_grant <= 0;
    repeat (4) begin
      repeat (6) @(posedge sys_clk);
      io_refresh <= 1;
      @(posedge sys_clk) io_refresh <= 0;
    end
    chk(eth_count === 7'h07, "early timeout");
    repeat (14) @(posedge sys_clk);
    io_release <= 1;
    @(posedge sys_clk) io_release <= 0;
    repeat (4) @(posedge sys_clk);
    chk(eth_count === 7'h08, "timeout not logged");
    rd(1, 7);
    chk(r.status === 8'h88 && r.detail === 8'h3c, "timeout record");
    chk(disp_chars === 16'h4c38 || disp_chars === 16'h3343, "timeout display");
  endtask
  task t_eth_wrap_fatal;
    for (int j = 0; j < 60; j++) send(1, {5'h0, 4'h2, 8'(8 + j)});
    chk(eth_count === error_history_pkg::ETH_DEPTH, "eth depth");
    rd(1, 0);
    chk(r.status === 8'h85 && r.detail === 8'h04, "eth oldest");
    repeat (4) @(posedge sys_clk);
    s0 = stored;
    send(1, 17'h0);
    chk(network_status_lamp === 2'h0 && module_status_lamp === 2'h2, "fatal lamps");
    chk(nvm_wr_valid === 1'b1 && nvm_wr_data.status === 8'h80, "fatal record save");
    repeat (20) @(posedge sys_clk);
    chk(disp_chars === 16'h5546 && stored == s0 + 1, "fatal display or save");
  endtask
  task t_clear;
    @(posedge sys_clk) clr_req <= 1;
    n = 0;
    do @(negedge sys_clk) n++; while (clr_ready !== 1'b1 && n < 100);
    @(posedge sys_clk) clr_req <= 0;
    #1 chk(main_count === 7'h0 && eth_count === 7'h0, "clear counts");
    repeat (4) @(posedge sys_clk);
    chk(stored == 0, "store not erased");
    rd(0, 0);
    chk(rd_hit === 1'b0 && r === 32'h0, "cleared read");
  endtask
  task t_legacy;
    @(posedge sys_clk) arst_n <= 0;
    legacy_mode <= 1;
    repeat (8) @(posedge sys_clk);
    arst_n <= 1;
    n = 0;
    do @(negedge sys_clk) n++; while (gen_ready !== 1'b1 && n < 100);
    chk(main_count === 7'h00 && network_status_lamp === 2'h1, "restore after reset");
    for (int j = 0; j < 21; j++) send(0, {8'h03, 8'(j), 1'b0});
    chk(main_count === error_history_pkg::LEGACY_DEPTH, "legacy depth");
    rd(0, 0);
    chk(r.status === 8'h03 && r.detail === 8'h01, "legacy oldest");
  endtask
  initial forever #5 sys_clk = ~sys_clk;
  initial begin
    #100us;
    err_count++;
    summarize;
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    arst_n <= 1;
    t_restore_gen;
    t_main_wrap;
    t_eth_kinds;
    t_watchdog;
    t_eth_wrap_fatal;
    t_clear;
    t_legacy;
    summarize;
  end
endmodule
`default_nettype wire

// >>> error_history_pkg.sv
// Purpose: shared constants and types of the error history logger
// Assumes: 100 MHz system clock
// Notes:   long counts are overridden at the top level for simulation
`default_nettype none
package error_history_pkg;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned     CLK_HZ     = 100_000_000;
  localparam int unsigned     OPTIME_MIN = 6;
  localparam longint unsigned OPTIME_CYC = 64'(OPTIME_MIN) * 64'd60 * 64'(CLK_HZ);
  localparam int unsigned     ALT_MS     = 500;
  localparam int unsigned     ALT_CYC    = ALT_MS * (CLK_HZ / 1000);
  // ****************************************************************
  // table sizes and codes
  // ****************************************************************
  localparam logic [6:0]  MAIN_DEPTH   = 7'h64;
  localparam logic [6:0]  LEGACY_DEPTH = 7'h14;
  localparam logic [6:0]  ETH_DEPTH    = 7'h40;
  localparam logic [7:0]  STATUS_ETH   = 8'h80;
  localparam logic [15:0] SHOW_N4      = 16'h6e34;
  localparam logic [15:0] SHOW_BLANK   = 16'h2020;
  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [3:0] {
    ek_adaptor = 4'h0, ek_ip_dup = 4'h1, ek_bootp = 4'h2, ek_basic = 4'h3,
    ek_mem     = 4'h4, ek_comm   = 4'h5, ek_tag   = 4'h6, ek_link  = 4'h7,
    ek_wto     = 4'h8
  } eth_kind_t;
  typedef enum logic [1:0] {
    lamp_off = 2'h0, lamp_green = 2'h1, lamp_red = 2'h2, lamp_red_flash = 2'h3
  } lamp_t;
  typedef enum logic [2:0] {
    st_restore = 3'h1, st_wait = 3'h2, st_idle = 3'h4
  } fsm_t;
  typedef struct packed {
    logic [7:0]  status;
    logic [15:0] optime;
    logic [7:0]  detail;
  } record_t;
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] detail;
    logic       critical;
  } gen_evt_t;
  typedef struct packed {
    eth_kind_t  kind;
    logic [7:0] detail;
  } eth_evt_t;
  typedef struct packed {
    fsm_t                          fsm;
    record_t [MAIN_DEPTH-7'h1:0]   main_mem;
    record_t [ETH_DEPTH-7'h1:0]    eth_mem;
    logic [6:0]                    main_head;
    logic [6:0]                    main_cnt;
    logic [6:0]                    eth_head;
    logic [6:0]                    eth_cnt;
    logic [6:0]                    rst_idx;
    logic                          nvm_wr_pend;
    record_t                       nvm_wr_rec;
    logic                          nvm_er_pend;
    logic                          rd_valid;
    logic                          rd_hit;
    record_t                       rd_data;
    logic [35:0]                   optime_div;
    logic [15:0]                   optime;
    logic [31:0]                   alt_div;
    logic                          alt_phase;
    lamp_t                         net_lamp;
    lamp_t                         mod_lamp;
    logic                          shown;
    eth_kind_t                     shown_kind;
    logic [7:0]                    shown_node;
    logic                          fatal;
    logic [15:0]                   disp;
    logic                          wto_active;
    logic [15:0]                   wto_cnt;
    logic                          wto_pend;
  } state_t;
  localparam state_t STATE_RST = '{fsm: st_restore, net_lamp: lamp_green,
                                   mod_lamp: lamp_green, shown_kind: ek_adaptor,
                                   disp: SHOW_BLANK, default: '0};
  // two display characters shown for each ethernet error
  function automatic logic [15:0] code_of(input eth_kind_t k);
    case (k)
      ek_adaptor: return 16'h5546;
      ek_ip_dup:  return 16'h4630;
      ek_bootp:   return 16'h4533;
      ek_basic:   return 16'h4632;
      ek_mem:     return 16'h4539;
      ek_comm:    return 16'h4634;
      ek_tag:     return 16'h4c39;
      ek_link:    return 16'h4531;
      ek_wto:     return 16'h4c38;
      default:    return 16'h2d2d;
    endcase
  endfunction
  function automatic logic [7:0] hex_ch(input logic [3:0] n);
    if (n < 4'ha) return 8'h30 + {4'h0, n};
    return 8'h37 + {4'h0, n};
  endfunction
endpackage
`default_nettype wire

// >>> error_history_pkg_unused_guard.sv
`default_nettype none
`default_nettype wire

// >>> nvm_store_model.sv
// Purpose: nonvolatile error store partner model
// Assumes: one request at a time from the logger
// Notes:   preloaded with two records; idle read data toggles
`timescale 1ns/10ps
`default_nettype none
module nvm_store_model (
  input  wire logic                       sys_clk,
  input  wire logic                       nvm_rd_req,
  input  wire logic [6:0]                 nvm_rd_idx,
  output logic                            nvm_rd_valid,
  output logic                            nvm_rd_end,
  output error_history_pkg::record_t      nvm_rd_data,
  input  wire logic                       nvm_wr_valid,
  input  wire error_history_pkg::record_t nvm_wr_data,
  output logic                            nvm_wr_ready,
  input  wire logic                       nvm_erase,
  output logic                            nvm_erase_done,
  output int                              stored
);
  // ****************
  // store behaviour
  // ****************
  error_history_pkg::record_t mem [$] = '{32'h010000a0, 32'h020000a1};
  initial begin
    {nvm_rd_valid, nvm_rd_end, nvm_wr_ready, nvm_erase_done} = 4'h0;
    nvm_rd_data = '0;
    stored = 2;
  end
  always @(posedge sys_clk) begin
    nvm_rd_valid <= nvm_rd_req;
    nvm_rd_end <= nvm_rd_req && (nvm_rd_idx >= mem.size());
    nvm_rd_data <= (nvm_rd_req && nvm_rd_idx < mem.size()) ? mem[nvm_rd_idx] : ~nvm_rd_data;
    nvm_wr_ready <= nvm_wr_valid && !nvm_wr_ready;
    nvm_erase_done <= nvm_erase && !nvm_erase_done;
    if (nvm_wr_valid && nvm_wr_ready) begin
      mem.push_back(nvm_wr_data);
      stored <= stored + 1;
    end
    if (nvm_erase && nvm_erase_done) begin
      mem.delete();
      stored <= 0;
    end
  end
endmodule
`default_nettype wire
